/* File: rtl/cmp_ctl_pkg.sv */
package cmp_ctl_pkg;

  localparam int unsigned NUM_CMP = 2;

  // Register map on the plain register port
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_SPEED0 = 3'h1;
  localparam logic [2:0] OFS_CTRL1 = 3'h2;
  localparam logic [2:0] OFS_SPEED1 = 3'h3;
  localparam logic [2:0] OFS_RESET_SRC = 3'h4;

  // Control register fields
  localparam int unsigned CTL_ON_BIT = 7;
  localparam int unsigned CTL_RESULT_BIT = 6;
  localparam int unsigned CTL_RISE_BIT = 5;
  localparam int unsigned CTL_FALL_BIT = 4;
  localparam int unsigned CTL_UHYS_LSB = 2;
  localparam int unsigned CTL_LHYS_LSB = 0;

  // Speed register fields
  localparam int unsigned SPD_RMASK_BIT = 5;
  localparam int unsigned SPD_FMASK_BIT = 4;
  localparam int unsigned SPD_MODE_LSB = 0;

  // Reset source register field
  localparam int unsigned RST_SRC_BIT = 0;

  // Hysteresis codes
  localparam logic [1:0] HYS_OFF = 2'h0;
  localparam logic [1:0] HYS_5MV = 2'h1;
  localparam logic [1:0] HYS_10MV = 2'h2;
  localparam logic [1:0] HYS_20MV = 2'h3;

  // Response mode codes, fastest to slowest
  localparam logic [1:0] MODE_FAST = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_SLOW = 2'h3;

  // Reset values
  localparam logic [1:0] MODE_RESET = MODE_2;
  localparam logic [1:0] HYS_RESET = HYS_OFF;

  // Analog settings toward one comparator core
  typedef struct packed {
    logic power_down;
    logic [1:0] speed_mode;
    logic [1:0] upper_hysteresis_sel;
    logic [1:0] lower_hysteresis_sel;
  } analog_cfg_t;

  // Per comparator state
  typedef struct packed {
    logic comparator_on;
    logic rise_seen_flag;
    logic fall_seen_flag;
    logic [1:0] upper_hysteresis_sel;
    logic [1:0] lower_hysteresis_sel;
    logic rise_irq_mask;
    logic fall_irq_mask;
    logic [1:0] speed_mode;
    logic sync1;
    logic sync2;
    logic prev;
  } cmp_state_t;

  typedef struct packed {
    cmp_state_t [NUM_CMP-1:0] cmp;
    logic reset_src_en;
    logic [7:0] rdata;
  } ctl_state_t;

endpackage

/* File: rtl/dual_comparator_control.sv */
module dual_comparator_control
  import cmp_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [cmp_ctl_pkg::NUM_CMP-1:0] core_result,
  output cmp_ctl_pkg::analog_cfg_t [cmp_ctl_pkg::NUM_CMP-1:0] core_cfg,
  output logic cmp0_raw_out,
  output logic cmp1_raw_out,
  output logic cmp0_latched_out,
  output logic cmp1_latched_out,
  output logic [cmp_ctl_pkg::NUM_CMP-1:0] cmp_irq,
  output logic cmp0_reset_req
);
  import cmp_ctl_pkg::*;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic [NUM_CMP-1:0] raw;
  logic [NUM_CMP-1:0] latched;
  logic [NUM_CMP-1:0] rise_ev;
  logic [NUM_CMP-1:0] fall_ev;
  logic [NUM_CMP-1:0] wr_ctl_hit;
  logic [NUM_CMP-1:0] wr_spd_hit;
  logic [NUM_CMP-1:0] rd_ctl_hit;
  logic [NUM_CMP-1:0] rd_spd_hit;
  logic [NUM_CMP-1:0][7:0] ctl_image;
  logic [NUM_CMP-1:0][7:0] spd_image;
  logic wr_rsrc_hit;
  logic rd_rsrc_hit;
  logic [7:0] rsrc_image;

  // Control image; result bit shows the gated synchronised value
  function automatic logic [7:0] ctl_word(cmp_state_t s, logic res);
    logic [7:0] w;
    w = 8'h00;
    w[CTL_ON_BIT] = s.comparator_on;
    w[CTL_RESULT_BIT] = res;
    w[CTL_RISE_BIT] = s.rise_seen_flag;
    w[CTL_FALL_BIT] = s.fall_seen_flag;
    w[CTL_UHYS_LSB +: 2] = s.upper_hysteresis_sel;
    w[CTL_LHYS_LSB +: 2] = s.lower_hysteresis_sel;
    return w;
  endfunction

  // Speed image; unused bits read zero
  function automatic logic [7:0] spd_word(cmp_state_t s);
    logic [7:0] w;
    w = 8'h00;
    w[SPD_RMASK_BIT] = s.rise_irq_mask;
    w[SPD_FMASK_BIT] = s.fall_irq_mask;
    w[SPD_MODE_LSB +: 2] = s.speed_mode;
    return w;
  endfunction

  // Flags store what is written, so software clears them with a zero
  function automatic cmp_state_t ctl_write(cmp_state_t s, logic [7:0] d);
    cmp_state_t n;
    n = s;
    n.comparator_on = d[CTL_ON_BIT];
    n.rise_seen_flag = d[CTL_RISE_BIT];
    n.fall_seen_flag = d[CTL_FALL_BIT];
    n.upper_hysteresis_sel = d[CTL_UHYS_LSB +: 2];
    n.lower_hysteresis_sel = d[CTL_LHYS_LSB +: 2];
    return n;
  endfunction

  function automatic cmp_state_t spd_write(cmp_state_t s, logic [7:0] d);
    cmp_state_t n;
    n = s;
    n.rise_irq_mask = d[SPD_RMASK_BIT];
    n.fall_irq_mask = d[SPD_FMASK_BIT];
    n.speed_mode = d[SPD_MODE_LSB +: 2];
    return n;
  endfunction

  // Synchroniser: nothing but the second stage reads the first
  function automatic cmp_state_t sync_step(cmp_state_t s, logic core);
    cmp_state_t n;
    n = s;
    n.sync1 = core;
    n.sync2 = s.sync1;
    // History tracks the gated value, so a disabled core stays quiet
    n.prev = s.sync2 & s.comparator_on;
    return n;
  endfunction

  // Edges are applied last, so a set beats a clearing write
  function automatic cmp_state_t edge_step(cmp_state_t s, logic rise,
    logic fall);
    cmp_state_t n;
    n = s;
    if (rise)
      n.rise_seen_flag = 1'b1;
    if (fall)
      n.fall_seen_flag = 1'b1;
    return n;
  endfunction

  // Raw path is pure gating, so it keeps working with the clock stopped
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++)
    begin : g_cmp
      localparam logic [2:0] CTL_OFS = (g == 0) ? OFS_CTRL0 : OFS_CTRL1;
      localparam logic [2:0] SPD_OFS = (g == 0) ? OFS_SPEED0 : OFS_SPEED1;
      assign raw[g] =
        core_result[g] & st_r.cmp[g].comparator_on;
      assign latched[g] =
        st_r.cmp[g].sync2 & st_r.cmp[g].comparator_on;
      assign rise_ev[g] = latched[g] & ~st_r.cmp[g].prev;
      assign fall_ev[g] = ~latched[g] & st_r.cmp[g].prev;
      assign wr_ctl_hit[g] = reg_wr & (reg_addr == CTL_OFS);
      assign wr_spd_hit[g] = reg_wr & (reg_addr == SPD_OFS);
      assign rd_ctl_hit[g] = reg_rd & (reg_addr == CTL_OFS);
      assign rd_spd_hit[g] = reg_rd & (reg_addr == SPD_OFS);
      assign ctl_image[g] = ctl_word(st_r.cmp[g], latched[g]);
      assign spd_image[g] = spd_word(st_r.cmp[g]);
      assign core_cfg[g].power_down = ~st_r.cmp[g].comparator_on;
      assign core_cfg[g].speed_mode = st_r.cmp[g].speed_mode;
      assign core_cfg[g].upper_hysteresis_sel =
        st_r.cmp[g].upper_hysteresis_sel;
      assign core_cfg[g].lower_hysteresis_sel =
        st_r.cmp[g].lower_hysteresis_sel;
      // One request line carries both edge kinds
      assign cmp_irq[g] =
        (st_r.cmp[g].rise_seen_flag & st_r.cmp[g].rise_irq_mask) |
        (st_r.cmp[g].fall_seen_flag & st_r.cmp[g].fall_irq_mask);
    end
  endgenerate

  assign wr_rsrc_hit = reg_wr & (reg_addr == OFS_RESET_SRC);
  assign rd_rsrc_hit = reg_rd & (reg_addr == OFS_RESET_SRC);
  assign rsrc_image = {7'h00, st_r.reset_src_en};

  assign cmp0_raw_out = raw[0];
  assign cmp1_raw_out = raw[1];
  assign cmp0_latched_out = latched[0];
  assign cmp1_latched_out = latched[1];
  // Comparator 1 has no reset path by construction
  assign cmp0_reset_req = st_r.reset_src_en & st_r.cmp[0].comparator_on
    & ~st_r.cmp[0].sync2;
  assign reg_rdata = st_r.rdata;

  // Unmapped reads fall through to zero
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    for (int i = 0; i < NUM_CMP; i++)
    begin
      st_nxt.cmp[i] = sync_step(st_r.cmp[i], core_result[i]);
      if (wr_ctl_hit[i])
        st_nxt.cmp[i] = ctl_write(st_nxt.cmp[i], reg_wdata);
      if (wr_spd_hit[i])
        st_nxt.cmp[i] = spd_write(st_nxt.cmp[i], reg_wdata);
      // Enable or setting changes may glitch; software cleans up
      st_nxt.cmp[i] = edge_step(st_nxt.cmp[i], rise_ev[i], fall_ev[i]);
      if (rd_ctl_hit[i])
        st_nxt.rdata = ctl_image[i];
      if (rd_spd_hit[i])
        st_nxt.rdata = spd_image[i];
    end
    if (wr_rsrc_hit)
      st_nxt.reset_src_en = reg_wdata[RST_SRC_BIT];
    if (rd_rsrc_hit)
      st_nxt.rdata = rsrc_image;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CMP; i++)
      begin
        st_r.cmp[i].comparator_on <= 1'b0;
        st_r.cmp[i].rise_seen_flag <= 1'b0;
        st_r.cmp[i].fall_seen_flag <= 1'b0;
        st_r.cmp[i].upper_hysteresis_sel <= HYS_RESET;
        st_r.cmp[i].lower_hysteresis_sel <= HYS_RESET;
        st_r.cmp[i].rise_irq_mask <= 1'b0;
        st_r.cmp[i].fall_irq_mask <= 1'b0;
        st_r.cmp[i].speed_mode <= MODE_RESET;
        st_r.cmp[i].sync1 <= 1'b0;
        st_r.cmp[i].sync2 <= 1'b0;
        st_r.cmp[i].prev <= 1'b0;
      end
      st_r.reset_src_en <= 1'b0;
      st_r.rdata <= 8'h00;
    end
    else
      st_r <= st_nxt;
  end

endmodule

/* File: tb/cmp_ctl_asserts.sv */
module cmp_ctl_asserts
  import cmp_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [cmp_ctl_pkg::NUM_CMP-1:0] core_result,
  input wire cmp_ctl_pkg::analog_cfg_t [cmp_ctl_pkg::NUM_CMP-1:0] core_cfg,
  input wire logic cmp0_raw_out,
  input wire logic cmp0_latched_out,
  input wire logic [cmp_ctl_pkg::NUM_CMP-1:0] cmp_irq,
  input wire logic cmp0_reset_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic off0 = core_cfg[0].power_down;
  wire logic rd0 = reg_rd && reg_addr == OFS_CTRL0;
  AST_RAW: assert property (cmp0_raw_out == (core_result[0] && !off0))
    else $error("raw out wrong");
  AST_OFF_LOW: assert property (off0 |-> !cmp0_latched_out)
    else $error("latched high while off");
  AST_SYNC: assert property (!off0 && $past(!off0, 2)
    |-> cmp0_latched_out == $past(core_result[0], 2))
    else $error("sync path wrong");
  AST_RESULT_RD: assert property (rd0
    |=> reg_rdata[CTL_RESULT_BIT] == $past(cmp0_latched_out))
    else $error("result bit wrong");
  AST_ON_RD: assert property (rd0 |=> reg_rdata[CTL_ON_BIT] == !$past(off0))
    else $error("enable bit wrong");
  AST_IRQ_HOLD: assert property (cmp_irq[0] && !reg_wr |=> cmp_irq[0])
    else $error("irq dropped");
  AST_IRQ_CAUSE: assert property ($rose(cmp_irq[0]) |-> $past(reg_wr)
    || $past(reg_wr, 2)
    || $past(core_result[0], 3) != $past(core_result[0], 4))
    else $error("irq without cause");
  AST_RST_REQ: assert property (cmp0_reset_req |-> !off0 && !cmp0_latched_out)
    else $error("reset request wrong");
  COV_IRQ: cover property ($rose(cmp_irq[0]));
  COV_RST: cover property ($rose(cmp0_reset_req));
  COV_LAT: cover property ($fell(cmp0_latched_out));
endmodule

bind dual_comparator_control cmp_ctl_asserts u_cmp_ctl_asserts (.clk, .rst_n,
  .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .core_result, .core_cfg,
  .cmp0_raw_out, .cmp0_latched_out, .cmp_irq, .cmp0_reset_req);

/* File: tb/cmp_core_model.sv */
module cmp_core_model
  import cmp_ctl_pkg::*;
(
  input wire logic [cmp_ctl_pkg::NUM_CMP-1:0] level,
  input wire cmp_ctl_pkg::analog_cfg_t [cmp_ctl_pkg::NUM_CMP-1:0] cfg,
  output logic [cmp_ctl_pkg::NUM_CMP-1:0] core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  // Powered-down core gives junk, never the held value
  always_comb
  begin
    for (int i = 0; i < NUM_CMP; i++)
      core_result[i] = cfg[i].power_down ? !level[i] : level[i];
  end
endmodule

/* File: tb/tb_dual_comparator_control.sv */
module tb_dual_comparator_control
  import cmp_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] level = 2'h0;
  logic [7:0] reg_rdata;
  logic [1:0] core_result, raw, lat, cmp_irq;
  logic cmp0_reset_req;
  analog_cfg_t [1:0] core_cfg;
  int miscompares = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  cmp_core_model u_cmp_core_model (.level, .cfg(core_cfg), .core_result);
  dual_comparator_control u_dual_comparator_control (.clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_result,
    .core_cfg, .cmp0_raw_out(raw[0]), .cmp1_raw_out(raw[1]),
    .cmp0_latched_out(lat[0]), .cmp1_latched_out(lat[1]), .cmp_irq,
    .cmp0_reset_req);
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] exp, string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(what, reg_rdata, exp);
  endtask
  task automatic wi(logic [2:0] a, logic [7:0] d, int i, logic e);
    wr(a, d);
    chk("irq", {7'h00, cmp_irq[i]}, {7'h00, e});
  endtask
  task automatic t_reset();
    chk("cfg0", {1'b0, core_cfg[0]}, 8'h60);
    rd(OFS_SPEED1, 8'h02, "speed1");
    rd(OFS_RESET_SRC, 8'h00, "rsrc");
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00, "unmapped");
  endtask
  task automatic t_cfg(logic [2:0] c, logic [2:0] s, int i);
    for (int k = 0; k < 4; k++)
    begin
      wr(c, {4'h0, k[1:0], ~k[1:0]});
      wr(s, {6'h00, k[1:0]});
      chk("cfg", {1'b0, core_cfg[i]}, {2'h1, {2{k[1:0]}}, ~k[1:0]});
      rd(c, {4'h0, k[1:0], ~k[1:0]}, "ctrl");
    end
  endtask
  task automatic t_edge(logic [2:0] c, logic [2:0] s, int i);
    wr(c, 8'h80);
    wr(s, 8'h30);
    wi(c, 8'h80, i, 1'b0);
    @(posedge clk) level[i] <= 1'b1;
    #1 chk("raw", {7'h00, raw[i]}, 8'h01);
    tick(3);
    chk("out", {6'h00, raw[i], lat[i]}, 8'h03);
    rd(c, 8'he0, "rise");
    @(posedge clk) level[i] <= 1'b0;
    tick(3);
    rd(c, 8'hb0, "both");
    wi(s, 8'h00, i, 1'b0);
    wi(c, 8'h90, i, 1'b0);
    wi(s, 8'h20, i, 1'b0);
    wi(s, 8'h10, i, 1'b1);
    wi(c, 8'h80, i, 1'b0);
    @(posedge clk) level[i] <= 1'b1;
    wr(c, 8'h00);
    tick(3);
    chk("off", {5'h00, raw[i], lat[i], core_cfg[i].power_down}, 8'h01);
  endtask
  task automatic t_rsrc();
    wr(OFS_RESET_SRC, 8'h01);
    wr(OFS_CTRL0, 8'h80);
    @(posedge clk) level[0] <= 1'b0;
    tick(3);
    chk("rreq", {7'h00, cmp0_reset_req}, 8'h01);
    @(posedge clk) level[0] <= 1'b1;
    tick(3);
    chk("rreq", {7'h00, cmp0_reset_req}, 8'h00);
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_cfg(OFS_CTRL0, OFS_SPEED0, 0);
    t_edge(OFS_CTRL0, OFS_SPEED0, 0);
    t_cfg(OFS_CTRL1, OFS_SPEED1, 1);
    t_edge(OFS_CTRL1, OFS_SPEED1, 1);
    t_rsrc();
    print_verdict();
  end
endmodule
